// ---- inc/rsc_pkg.sv ----
// constants, register map and carrier types of the reset source capture block
package rsc_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [31:0] RESET_FLAGS_ADDR = 32'hFFFFF888;
  localparam logic [31:0] PROTECT_CMD_ADDR = 32'hFFFFF880;
  localparam logic [31:0] DEBUG_MODE_ADDR  = 32'hFFFFF884;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int          WDT_FLAG_BIT     = 4;
  localparam int          CLM_FLAG_BIT     = 1;
  localparam int          LVI_FLAG_BIT     = 0;
  localparam logic [7:0]  FLAGS_RESET      = 8'h00;
  localparam logic [7:0]  FLAGS_USED_MASK  = 8'h13;
  localparam logic [7:0]  DEBUG_MODE_RESET = 8'h01;
  localparam logic [7:0]  DEBUG_USED_MASK  = 8'h01;
  localparam int          DEBUG_ENABLE_BIT = 0;
  localparam logic [2:0]  CPU_DIV_8        = 3'h3;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS    = 10;
  localparam int OSC_STAB_TIME_NS = 10240;
  localparam int OSC_STAB_CYCLES  = (OSC_STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WDT_COUNT_W      = 16;

  // ****************************************
  // carrier types
  // ****************************************
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        bit_access;
    logic [2:0]  bit_sel;
    logic [31:0] addr;
    logic [7:0]  wdata;
  } rsc_bus_req_t;

  typedef struct packed {
    logic wdt;
    logic clock_monitor;
    logic low_voltage_detector;
  } rsc_src_t;

  typedef struct packed {
    logic       main_osc_en;
    logic       int_osc_en;
    logic       sub_osc_en;
    logic       periph_clk_en;
    logic       sys_clk_en;
    logic       cpu_clk_en;
    logic [2:0] cpu_div;
  } rsc_clk_ctrl_t;

  typedef enum logic [1:0] {
    ST_HOLD,
    ST_STAB,
    ST_RUN
  } rsc_state_t;

endpackage

// ---- src/rsc_reset_ctrl.sv ----
// reset control with reset source flag register and hardware reset states
//
// Summary of operation
// - flag register writes take effect only right after the protect command write
// - flag register is read and written as a whole byte or a single bit
// - external pin reset clears all flag bits to 00H
// - bit 4 reads 1 after a watchdog reset, else 0
// - bit 1 reads 1 after a clock monitor reset, else 0
// - bit 0 reads 1 after a low voltage reset, else 0
// - an internal reset sets only its own flag, others keep their values
// - software can only clear flags by writing zero, never set them
// - a flag set event beats a same-cycle software clear
// - while the pin is low the system is held in reset and initialised
// - reset is left when the pin goes from low to high
// - main and internal oscillators stop in reset, subclock keeps running
// - peripheral clocks start only after the stabilisation time
// - system and cpu clocks resume after stabilisation, cpu clock at divide by 8
// - cpu is initialised in reset, runs only after stabilisation
// - watchdog counter cleared in reset, counts internal oscillator ticks after
// - ram kept through reset unless power-on or access collides with reset
// - pin reset initialises peripheral registers, debug mode register to 01H
// - other peripherals stop in reset, may run after stabilisation
`timescale 1ns/1ps
module rsc_reset_ctrl #(
  parameter int OSC_STAB_CYCLES = rsc_pkg::OSC_STAB_CYCLES,
  parameter int WDT_W           = rsc_pkg::WDT_COUNT_W
) (
  // clock and block reset
  input  wire logic                   sys_clk,
  input  wire logic                   srst,
  // reset sources
  input  wire logic                   reset_pin_n,
  input  wire rsc_pkg::rsc_src_t      src_req,
  // activity inputs
  input  wire logic                   int_osc_tick,
  input  wire logic                   cpu_ram_access,
  // register port
  input  wire rsc_pkg::rsc_bus_req_t  bus_req,
  output logic [7:0]                  bus_rdata,
  // system control
  output logic                        sys_reset,
  output logic                        periph_init,
  output logic                        cpu_run,
  output logic                        io_hiz,
  output logic                        ram_retained,
  output rsc_pkg::rsc_clk_ctrl_t      clk_ctrl,
  output logic [WDT_W-1:0]            wdt_count,
  output logic                        debug_enable_bit
);

  // ****************************************
  // elaboration checks and constants
  // ****************************************
  if (OSC_STAB_CYCLES < 1) begin : g_chk_stab
    $error("OSC_STAB_CYCLES must be at least 1");
  end
  if (WDT_W < 1) begin : g_chk_wdt
    $error("WDT_W must be at least 1");
  end

  localparam int               STAB_W    = $clog2(OSC_STAB_CYCLES + 1);
  localparam logic [STAB_W-1:0] STAB_LAST = STAB_W'(OSC_STAB_CYCLES - 1);

  // ****************************************
  // declarations
  // ****************************************
  rsc_pkg::rsc_state_t state;
  rsc_pkg::rsc_state_t next_state;
  logic [STAB_W-1:0]   stab_cnt;
  logic [7:0]          reset_source_flags;
  logic [7:0]          debug_mode_register;
  logic                protect_armed;
  logic                pin_low;
  logic                src_any;
  logic [7:0]          ev_bits;
  logic [7:0]          bit_mask;
  logic [7:0]          keep_mask;
  logic                flags_wr_ok;
  logic [7:0]          next_flags;

  assign debug_enable_bit = debug_mode_register[rsc_pkg::DEBUG_ENABLE_BIT];

  // ****************************************
  // reset sequencing
  // ****************************************
  // source decode and next state
  always_comb begin
    pin_low    = ~reset_pin_n;
    src_any    = src_req.wdt | src_req.clock_monitor | src_req.low_voltage_detector;
    next_state = state;
    case (state)
      rsc_pkg::ST_HOLD: begin
        if (!pin_low && !src_any) begin
          next_state = rsc_pkg::ST_STAB;
        end
      end
      rsc_pkg::ST_STAB: begin
        if (pin_low || src_any) begin
          next_state = rsc_pkg::ST_HOLD;
        end else if (stab_cnt == STAB_LAST) begin
          next_state = rsc_pkg::ST_RUN;
        end
      end
      rsc_pkg::ST_RUN: begin
        if (pin_low || src_any) begin
          next_state = rsc_pkg::ST_HOLD;
        end
      end
      default: begin
        next_state = rsc_pkg::ST_HOLD;
      end
    endcase
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state <= rsc_pkg::ST_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // oscillation stabilisation counter
  always_ff @(posedge sys_clk) begin
    if (srst || state != rsc_pkg::ST_STAB) begin
      stab_cnt <= '0;
    end else begin
      stab_cnt <= stab_cnt + STAB_W'(1);
    end
  end

  // system reset, cpu, port and peripheral controls
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sys_reset   <= 1'b1;
      periph_init <= 1'b1;
      cpu_run     <= 1'b0;
      io_hiz      <= 1'b1;
    end else begin
      sys_reset   <= next_state == rsc_pkg::ST_HOLD;
      periph_init <= next_state == rsc_pkg::ST_HOLD;
      cpu_run     <= next_state == rsc_pkg::ST_RUN;
      io_hiz      <= next_state == rsc_pkg::ST_HOLD;
    end
  end

  // oscillator and clock enables
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      clk_ctrl.main_osc_en   <= 1'b0;
      clk_ctrl.int_osc_en    <= 1'b0;
      clk_ctrl.sub_osc_en    <= 1'b1;
      clk_ctrl.periph_clk_en <= 1'b0;
      clk_ctrl.sys_clk_en    <= 1'b0;
      clk_ctrl.cpu_clk_en    <= 1'b0;
      clk_ctrl.cpu_div       <= rsc_pkg::CPU_DIV_8;
    end else begin
      clk_ctrl.main_osc_en   <= next_state != rsc_pkg::ST_HOLD;
      clk_ctrl.int_osc_en    <= next_state != rsc_pkg::ST_HOLD;
      clk_ctrl.sub_osc_en    <= 1'b1;
      clk_ctrl.periph_clk_en <= next_state == rsc_pkg::ST_RUN;
      clk_ctrl.sys_clk_en    <= next_state == rsc_pkg::ST_RUN;
      clk_ctrl.cpu_clk_en    <= next_state == rsc_pkg::ST_RUN;
      if (next_state == rsc_pkg::ST_HOLD) begin
        clk_ctrl.cpu_div <= rsc_pkg::CPU_DIV_8;
      end
    end
  end

  // watchdog counter, cleared in reset, ticks on internal oscillator
  always_ff @(posedge sys_clk) begin
    if (srst || next_state == rsc_pkg::ST_HOLD) begin
      wdt_count <= '0;
    end else if (int_osc_tick) begin
      wdt_count <= wdt_count + WDT_W'(1);
    end
  end

  // ram status, lost at power-on or on access colliding with reset entry
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ram_retained <= 1'b0;
    end else if (state != rsc_pkg::ST_HOLD && next_state == rsc_pkg::ST_HOLD) begin
      ram_retained <= ~cpu_ram_access;
    end
  end

  // ****************************************
  // reset source flag register
  // ****************************************
  // event bits, write masks and next flag value
  always_comb begin
    ev_bits                         = 8'h00;
    ev_bits[rsc_pkg::WDT_FLAG_BIT]  = src_req.wdt;
    ev_bits[rsc_pkg::CLM_FLAG_BIT]  = src_req.clock_monitor;
    ev_bits[rsc_pkg::LVI_FLAG_BIT]  = src_req.low_voltage_detector;
    bit_mask    = 8'h01 << bus_req.bit_sel;
    flags_wr_ok = bus_req.wr && protect_armed &&
                  bus_req.addr == rsc_pkg::RESET_FLAGS_ADDR;
    if (!flags_wr_ok) begin
      keep_mask = 8'hFF;
    end else if (bus_req.bit_access) begin
      keep_mask = ~bit_mask | (bus_req.wdata[0] ? bit_mask : 8'h00);
    end else begin
      keep_mask = bus_req.wdata;
    end
    // only zeros clear, events win over clear
    next_flags = ((reset_source_flags & keep_mask) | ev_bits)
                 & rsc_pkg::FLAGS_USED_MASK;
  end

  // flag register
  always_ff @(posedge sys_clk) begin
    if (srst || pin_low) begin
      reset_source_flags <= rsc_pkg::FLAGS_RESET;
    end else begin
      reset_source_flags <= next_flags;
    end
  end

  // protect arm, valid only for the very next access
  always_ff @(posedge sys_clk) begin
    if (srst || pin_low) begin
      protect_armed <= 1'b0;
    end else if (bus_req.wr && bus_req.addr == rsc_pkg::PROTECT_CMD_ADDR) begin
      protect_armed <= 1'b1;
    end else if (bus_req.wr || bus_req.rd) begin
      protect_armed <= 1'b0;
    end
  end

  // debug mode register, set by pin reset, kept by internal resets
  always_ff @(posedge sys_clk) begin
    if (srst || pin_low) begin
      debug_mode_register <= rsc_pkg::DEBUG_MODE_RESET;
    end else if (bus_req.wr && bus_req.addr == rsc_pkg::DEBUG_MODE_ADDR) begin
      if (bus_req.bit_access) begin
        debug_mode_register <= ((debug_mode_register & ~bit_mask) |
                                (bus_req.wdata[0] ? bit_mask : 8'h00))
                               & rsc_pkg::DEBUG_USED_MASK;
      end else begin
        debug_mode_register <= bus_req.wdata & rsc_pkg::DEBUG_USED_MASK;
      end
    end
  end

  // read data, one cycle after the read strobe, zero elsewhere
  always_ff @(posedge sys_clk) begin
    if (srst || !bus_req.rd) begin
      bus_rdata <= 8'h00;
    end else begin
      case (bus_req.addr)
        rsc_pkg::RESET_FLAGS_ADDR: begin
          bus_rdata <= (bus_req.bit_access ? bit_mask : 8'hFF)
                       & reset_source_flags;
        end
        rsc_pkg::DEBUG_MODE_ADDR: begin
          bus_rdata <= (bus_req.bit_access ? bit_mask : 8'hFF) & debug_mode_register;
        end
        default: begin
          bus_rdata <= 8'h00;
        end
      endcase
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  property p_pin_clear;
    pin_low |=> reset_source_flags == rsc_pkg::FLAGS_RESET;
  endproperty
  a_pin_clear: assert property (p_pin_clear) else $error("pin reset left flags set");

  property p_wdt_flag;
    (src_req.wdt && !pin_low) |=> reset_source_flags[rsc_pkg::WDT_FLAG_BIT];
  endproperty
  a_wdt_flag: assert property (p_wdt_flag) else $error("watchdog flag not set");

  property p_clm_flag;
    (src_req.clock_monitor && !pin_low) |=> reset_source_flags[rsc_pkg::CLM_FLAG_BIT];
  endproperty
  a_clm_flag: assert property (p_clm_flag) else $error("clock monitor flag not set");

  property p_lvi_flag;
    (src_req.low_voltage_detector && !pin_low) |=> reset_source_flags[rsc_pkg::LVI_FLAG_BIT];
  endproperty
  a_lvi_flag: assert property (p_lvi_flag) else $error("low voltage flag not set");

  property p_others_kept;
    (src_req.wdt && !src_req.clock_monitor && !src_req.low_voltage_detector && !pin_low && !flags_wr_ok)
      |=> reset_source_flags[1:0] == $past(reset_source_flags[1:0]);
  endproperty
  a_others_kept: assert property (p_others_kept) else $error("other flags disturbed");

  property p_unprotected;
    (bus_req.wr && !protect_armed && !pin_low)
      |=> (($past(reset_source_flags) & ~reset_source_flags) == 8'h00);
  endproperty
  a_unprotected: assert property (p_unprotected) else $error("unprotected write landed");

  property p_no_sw_set;
    !pin_low |=> ((reset_source_flags & ~$past(reset_source_flags) & ~$past(ev_bits)) == 8'h00);
  endproperty
  a_no_sw_set: assert property (p_no_sw_set) else $error("flag set without an event");

  property p_set_wins;
    (flags_wr_ok && !pin_low && src_req.low_voltage_detector) |=> reset_source_flags[rsc_pkg::LVI_FLAG_BIT];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a set event");

  property p_unused_zero;
    (bus_req.rd && bus_req.addr == rsc_pkg::RESET_FLAGS_ADDR)
      |=> (bus_rdata & ~rsc_pkg::FLAGS_USED_MASK) == 8'h00;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bits read nonzero");

  property p_hold;
    pin_low |=> sys_reset && periph_init && io_hiz && !cpu_run;
  endproperty
  a_hold: assert property (p_hold) else $error("system not held in reset");

  property p_release;
    (state == rsc_pkg::ST_HOLD && !pin_low && !src_any) |=> !sys_reset;
  endproperty
  a_release: assert property (p_release) else $error("reset not released");

  property p_osc;
    sys_reset |-> !clk_ctrl.main_osc_en && !clk_ctrl.int_osc_en && clk_ctrl.sub_osc_en;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator state wrong in reset");

  property p_stab;
    $rose(clk_ctrl.periph_clk_en) |-> $past(state) == rsc_pkg::ST_STAB &&
                                      $past(stab_cnt) == STAB_LAST && cpu_run;
  endproperty
  a_stab: assert property (p_stab) else $error("clocks started before stabilisation");

  property p_cpu_div;
    $rose(clk_ctrl.cpu_clk_en)
      |-> clk_ctrl.cpu_div == rsc_pkg::CPU_DIV_8 && clk_ctrl.sys_clk_en;
  endproperty
  a_cpu_div: assert property (p_cpu_div) else $error("cpu clock not at divide by 8");

  property p_wdt_clear;
    sys_reset |-> wdt_count == '0;
  endproperty
  a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog count not cleared");

  property p_debug_init;
    pin_low |=> debug_mode_register == rsc_pkg::DEBUG_MODE_RESET;
  endproperty
  a_debug_init: assert property (p_debug_init) else $error("debug register not 01H");

  // read data stands only after a read strobe
  property p_rd_idle;
    !bus_req.rd |=> bus_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without a read");

  // protect arm is spent by the next other access
  property p_protect_once;
    (protect_armed && (bus_req.wr || bus_req.rd) && bus_req.addr != rsc_pkg::PROTECT_CMD_ADDR)
      |=> !protect_armed;
  endproperty
  a_protect_once: assert property (p_protect_once) else $error("protect arm outlived access");

  // ram marked lost when an access collides with reset entry
  property p_ram_collide;
    (state != rsc_pkg::ST_HOLD && next_state == rsc_pkg::ST_HOLD && cpu_ram_access)
      |=> !ram_retained;
  endproperty
  a_ram_collide: assert property (p_ram_collide) else $error("ram kept after collision");

endmodule

// ---- sim/rsc_src_model.sv ----
// behavioural model of the reset pin driver and the internal reset generators
`timescale 1ns/1ps
module rsc_src_model (
  // clock
  input  wire logic              sys_clk,
  // commands from the bench
  input  wire logic              pin_low_cmd,
  input  wire rsc_pkg::rsc_src_t src_cmd,
  input  wire logic              tick_en,
  input  wire logic [1:0]        tick_div,
  // device side
  output logic                   reset_pin_n,
  output rsc_pkg::rsc_src_t      src_req,
  output logic                   int_osc_tick
);
  logic [1:0] tick_cnt = 2'h0;
  logic       tick_q   = 1'h0;

  // pin held low while commanded, high otherwise
  assign reset_pin_n  = ~pin_low_cmd;
  // generators hold their request level while active
  assign src_req      = src_cmd;
  assign int_osc_tick = tick_q;
  // oscillator tick, one pulse every tick_div+1 cycles, slow or fast
  always_ff @(posedge sys_clk) begin
    tick_cnt <= (tick_cnt >= tick_div) ? 2'h0 : tick_cnt + 2'h1;
    tick_q   <= tick_en & (tick_cnt == 2'h0);
  end
endmodule

// ---- sim/testbench.sv ----
// self-checking bench for the reset source capture block
`timescale 1ns/1ps
module testbench;
  localparam int          STAB = 4;
  localparam logic [31:0] FLG  = rsc_pkg::RESET_FLAGS_ADDR;
  localparam logic [31:0] PRT  = rsc_pkg::PROTECT_CMD_ADDR;
  localparam logic [31:0] DBG  = rsc_pkg::DEBUG_MODE_ADDR;
  logic                   sys_clk        = 1'h0;
  logic                   srst           = 1'h1;
  logic                   pin_low_cmd    = 1'h0;
  logic                   tick_en        = 1'h0;
  logic [1:0]             tick_div       = 2'h0;
  logic                   cpu_ram_access = 1'h0;
  rsc_pkg::rsc_src_t      src_cmd        = '0;
  rsc_pkg::rsc_bus_req_t  bus_req        = '0;
  logic                   reset_pin_n, int_osc_tick;
  rsc_pkg::rsc_src_t      src_req;
  logic [7:0]             bus_rdata;
  logic                   sys_reset, periph_init, cpu_run, io_hiz, ram_retained, debug_enable_bit;
  rsc_pkg::rsc_clk_ctrl_t clk_ctrl;
  logic [15:0]            wdt_count;
  int                     fail_count = 0;
  int                     n_checks   = 0;
  int                     n_ticks    = 0;
  logic [7:0]             exp_flags  = 8'h00;
  logic [7:0]             rd_val;
  logic [2:0]             osc_en;
  logic [2:0]             clk_en;

  // oscillator and clock enables gathered for compact checks
  assign osc_en = {clk_ctrl.main_osc_en, clk_ctrl.int_osc_en, clk_ctrl.sub_osc_en};
  assign clk_en = {clk_ctrl.periph_clk_en, clk_ctrl.sys_clk_en, clk_ctrl.cpu_clk_en};

  // ****************************************
  // clock, partner and design
  // ****************************************
  always #5 sys_clk = ~sys_clk;

  rsc_src_model u_rsc_src_model (.sys_clk(sys_clk), .pin_low_cmd(pin_low_cmd),
    .src_cmd(src_cmd), .tick_en(tick_en), .tick_div(tick_div), .reset_pin_n(reset_pin_n),
    .src_req(src_req), .int_osc_tick(int_osc_tick));

  rsc_reset_ctrl #(.OSC_STAB_CYCLES(STAB), .WDT_W(16)) u_rsc_reset_ctrl (.sys_clk(sys_clk),
    .srst(srst), .reset_pin_n(reset_pin_n), .src_req(src_req), .int_osc_tick(int_osc_tick),
    .cpu_ram_access(cpu_ram_access), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .sys_reset(sys_reset), .periph_init(periph_init), .cpu_run(cpu_run), .io_hiz(io_hiz),
    .ram_retained(ram_retained), .clk_ctrl(clk_ctrl), .wdt_count(wdt_count),
    .debug_enable_bit(debug_enable_bit));

  // ticks the design should count, seen at the same edges
  always @(posedge sys_clk) begin
    if (int_osc_tick === 1'h1 && sys_reset === 1'h0) begin
      n_ticks <= n_ticks + 1;
    end
  end

  // ****************************************
  // checking and bus tasks
  // ****************************************
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic drive(input logic w, input logic r, input logic ba, input logic [2:0] sel,
                       input logic [31:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_req <= {w, r, ba, sel, a, d};
  endtask

  task automatic idle();
    @(posedge sys_clk);
    bus_req <= '0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic ba, input logic [2:0] sel, input logic [31:0] a);
    drive(1'h0, 1'h1, ba, sel, a, 8'h00);
    idle();
    #1 rd_val = bus_rdata;
  endtask

  // protect command followed at once by the flag write
  task automatic pwr(input logic ba, input logic [2:0] sel, input logic [7:0] d);
    drive(1'h1, 1'h0, 1'h0, 3'h0, PRT, 8'h00);
    drive(1'h1, 1'h0, ba, sel, FLG, d);
    idle();
  endtask

  function automatic logic [7:0] src_bits(input rsc_pkg::rsc_src_t s);
    logic [7:0] b;
    b = 8'h00;
    b[rsc_pkg::WDT_FLAG_BIT] = s.wdt;
    b[rsc_pkg::CLM_FLAG_BIT] = s.clock_monitor;
    b[rsc_pkg::LVI_FLAG_BIT] = s.low_voltage_detector;
    return b;
  endfunction

  // hold a reset for n cycles, check the held state, release and check restart timing
  task automatic hold_reset(input logic pin, input rsc_pkg::rsc_src_t s, input int n,
                            input logic ram);
    @(posedge sys_clk);
    pin_low_cmd    <= pin;
    src_cmd        <= s;
    cpu_ram_access <= ram;
    repeat (n) @(posedge sys_clk);
    #1;
    chk("sys_reset", sys_reset, 1'h1);
    chk("io_hiz", io_hiz, 1'h1);
    chk("periph_init", periph_init, 1'h1);
    chk("cpu_run", cpu_run, 1'h0);
    chk("osc_en", osc_en, 3'h1);
    chk("clk_en", clk_en, 3'h0);
    chk("wdt_count", wdt_count, 16'h0000);
    @(posedge sys_clk);
    pin_low_cmd    <= 1'h0;
    src_cmd        <= '0;
    cpu_ram_access <= 1'h0;
    @(posedge sys_clk);
    #1;
    chk("sys_reset", sys_reset, 1'h0);
    chk("osc_en", osc_en, 3'h7);
    repeat (STAB - 1) @(posedge sys_clk);
    #1;
    chk("cpu_run", cpu_run, 1'h0);
    @(posedge sys_clk);
    #1;
    chk("cpu_run", cpu_run, 1'h1);
    chk("clk_en", clk_en, 3'h7);
    chk("cpu_div", clk_ctrl.cpu_div, rsc_pkg::CPU_DIV_8);
    chk("ram_retained", ram_retained, !ram);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    int                i;
    int                k;
    rsc_pkg::rsc_src_t s;
    logic [7:0]        d;
    logic [2:0]        sel;
    logic              ba;
    void'($urandom(63228));
    repeat (4) @(posedge sys_clk);
    srst <= 1'h0;
    k = 0;
    while (cpu_run !== 1'h1 && k < 50) begin
      @(posedge sys_clk);
      #1 k++;
    end
    if (k >= 50) begin
      fail_count++;
      test_done();
    end
    rd(1'h0, 3'h0, FLG);
    chk("flags", rd_val, 8'h00);
    chk("debug_enable_bit", debug_enable_bit, 1'h1);
    // each internal source alone, the first colliding with a ram access
    for (i = 0; i < 3; i++) begin
      s = rsc_pkg::rsc_src_t'(3'h4 >> i);
      hold_reset(1'h0, s, i + 1, 1'(i == 0));
      exp_flags = exp_flags | src_bits(s);
      rd(1'h0, 3'h0, FLG);
      chk("flags", rd_val, exp_flags);
    end
    // protect spoiled by an intervening read, then two plain writes
    drive(1'h1, 1'h0, 1'h0, 3'h0, PRT, 8'h00);
    drive(1'h0, 1'h1, 1'h0, 3'h0, DBG, 8'h00);
    drive(1'h1, 1'h0, 1'h0, 3'h0, FLG, 8'h00);
    drive(1'h1, 1'h0, 1'h0, 3'h0, FLG, 8'h00);
    idle();
    rd(1'h0, 3'h0, FLG);
    chk("flags", rd_val, exp_flags);
    pwr(1'h1, 3'h4, 8'h00);
    exp_flags[4] = 1'h0;
    rd(1'h1, 3'h1, FLG);
    chk("flag bit", rd_val, 8'h02);
    pwr(1'h0, 3'h0, 8'hFF);
    rd(1'h0, 3'h0, FLG);
    chk("flags", rd_val, exp_flags);
    rd(1'h0, 3'h0, 32'hFFFFF890);
    chk("unmapped", rd_val, 8'h00);
    // watchdog counts oscillator ticks from zero
    @(posedge sys_clk);
    tick_div <= 2'($urandom());
    tick_en  <= 1'h1;
    repeat (40) @(posedge sys_clk);
    tick_en <= 1'h0;
    repeat (4) @(posedge sys_clk);
    #1 chk("wdt_count", wdt_count, 16'(n_ticks));
    // software clears the debug enable bit after release
    drive(1'h1, 1'h0, 1'h0, 3'h0, DBG, 8'h00);
    idle();
    #1 chk("debug_enable_bit", debug_enable_bit, 1'h0);
    // clear of all flags in the same cycle as a low voltage event
    drive(1'h1, 1'h0, 1'h0, 3'h0, PRT, 8'h00);
    drive(1'h1, 1'h0, 1'h0, 3'h0, FLG, 8'h00);
    src_cmd <= rsc_pkg::rsc_src_t'(3'h1);
    idle();
    src_cmd <= '0;
    rd(1'h0, 3'h0, FLG);
    chk("flags", rd_val, 8'h01);
    hold_reset(1'h0, rsc_pkg::rsc_src_t'(3'h1), 1, 1'h0);
    exp_flags = 8'h01;
    rd(1'h0, 3'h0, FLG);
    chk("flags", rd_val, exp_flags);
    chk("debug_enable_bit", debug_enable_bit, 1'h0);
    // random sources and random writes, protected or not
    for (i = 0; i < 8; i++) begin
      s = rsc_pkg::rsc_src_t'(3'($urandom_range(7, 1)));
      hold_reset(1'h0, s, $urandom_range(4, 1), 1'($urandom_range(1, 0)));
      exp_flags = exp_flags | src_bits(s);
      d   = 8'($urandom());
      sel = 3'($urandom());
      ba  = 1'($urandom());
      if ($urandom_range(1, 0) == 1) begin
        drive(1'h1, 1'h0, ba, sel, FLG, d);
        idle();
      end else begin
        pwr(ba, sel, d);
        if (ba) begin
          exp_flags[sel] = exp_flags[sel] & d[0];
        end else begin
          exp_flags = exp_flags & d;
        end
      end
      rd(1'h0, 3'h0, FLG);
      chk("flags", rd_val, exp_flags);
      rd(1'h1, sel, FLG);
      chk("flag bit", rd_val, exp_flags & (8'h01 << sel));
    end
    // pin reset after a watchdog reset wipes the flags and sets debug mode
    hold_reset(1'h0, rsc_pkg::rsc_src_t'(3'h4), 1, 1'h0);
    hold_reset(1'h1, rsc_pkg::rsc_src_t'(3'h0), 3, 1'h0);
    rd(1'h0, 3'h0, FLG);
    chk("flags", rd_val, 8'h00);
    chk("debug_enable_bit", debug_enable_bit, 1'h1);
    test_done();
  end
endmodule
